// ---- hw/cycle_divider.sv ----
`timescale 1ns/100ps
// divider making one-cycle enables for machine cycle and strobe slots
module cycle_divider #(
    parameter int MAX_PERIODS = 12
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [4:0] periodCount,
    output logic cycleEnd,
    output logic halfPoint
);
    initial begin
        if (MAX_PERIODS < 2 || MAX_PERIODS > 31) $error("cycle_divider: bad MAX_PERIODS");
    end
    // running period count inside one machine cycle
    logic [4:0] count_r;
    always_ff @(posedge core_clk) begin
        if (rst || cycleEnd) begin
            count_r <= 5'h00;
        end else begin
            count_r <= count_r + 5'h01;
        end
    end
    // end of a cycle and its midpoint, for the two fetch strobes
    assign cycleEnd = (count_r >= periodCount - 5'h01);
    assign halfPoint = (count_r == (periodCount >> 1) - 5'h01);
endmodule : cycle_divider

// ---- hw/ext_bus_consts.svh ----
// offsets, field positions, reset values and timing counts of the external bus control
`ifndef EXT_BUS_CONSTS_SVH
`define EXT_BUS_CONSTS_SVH
`define AUX_CTRL_ADDR 8'h8E
`define CLK_CTRL0_ADDR 8'h8F
`define CLK_CTRL1_ADDR 8'h90
`define MEM_STATUS_ADDR 8'h91
`define AUX_PULLUP_DIS_BIT 7
`define AUX_STRETCH_BIT 5
`define AUX_XRS_HI_BIT 3
`define AUX_XRS_LO_BIT 2
`define AUX_EXTDATA_BIT 1
`define AUX_ALE_BIT 0
`define AUX_WRITE_MASK 8'hAF
`define CK0_CORE_X2_BIT 0
`define CK1_SPI_X2_BIT 0
`define XRS_RESET 2'h3
`define SLOW_PERIODS 12
`define FAST_PERIODS 6
`define STROBE_SHORT_PERIODS 6
`define STROBE_LONG_PERIODS 30
`endif

// ---- hw/ext_bus_ctrl.sv ----
`timescale 1ns/100ps
// external memory bus control with auxiliary and clock control registers
// Summary of operation
// RL1: port zero multiplexes low address then data
// RL2: bus mode drives ones strongly, not floating
// RL3: two fetch strobes per external code cycle
// RL4: data access cycle skips both fetch strobes
// RL5: no fetch strobe for internal code fetches
// RL6: board holds access select low for external
// RL7: protection level one latches access select
// RL8: double speed bit picks 12 or 6
// RL9: reset loads speed from security byte
// RL10: peripheral fast bits act only when doubled
// RL11: stretch clear gives 6 period strobes
// RL12: stretch set gives 30 period strobes
// RL13: pull-up disable removes weak port pull-ups
// RL14: software never sets reserved auxiliary bits
// RL15: data select routes expansion ram or bus
// RL16: size code picks 256 to 1024 bytes
`include "ext_bus_consts.svh"
module ext_bus_ctrl (
    input wire logic core_clk,
    input wire logic rst,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    output logic [7:0] wb_dat_o,
    output logic wb_ack_o,
    // security byte settings and straps
    input wire logic securityDoubleSpeed,
    input wire logic securityExtData,
    input wire logic protectLevel1,
    input wire logic externalAccessSelect_n,
    // core requests
    input wire ext_bus_pkg::bus_req_t coreReq,
    input wire logic [15:0] coreAddr,
    input wire logic [7:0] coreWrData,
    input wire logic internalCodeHit,
    output logic coreDone,
    output logic [7:0] coreRdData,
    output logic useExternalCode,
    output logic useExpansionRam,
    output logic [10:0] expansionRamBytes,
    output logic [6:0] periphFast,
    output logic weakPullupOn,
    output logic cycleTick,
    // external bus pins
    input wire logic [7:0] addrData_i,
    output logic [7:0] addrData_o,
    output logic [7:0] addrData_oe_n,
    output logic [7:0] addrHigh,
    output logic addrLatch,
    output logic programFetchStrobe_n,
    output logic readStrobe_n,
    output logic writeStrobe_n
);
    import ext_bus_pkg::*;

    // whole state of the block
    typedef struct packed {
        logic [7:0] aux;
        logic [7:0] clk0;
        logic [7:0] clk1;
        logic eaLatched;
        logic ack;
        bus_phase_t phase;
        bus_req_t req;
        logic [4:0] strobeCnt;
        logic [7:0] rdData;
        logic [7:0] busOut;
        logic busDrive;
        logic [7:0] addrHi;
        logic ale;
        logic fetchN;
        logic rdN;
        logic wrN;
        logic done;
        logic secondHalf;
    } state_t;
    state_t st_r, st_nxt;

    // stretch bit chooses strobe length
    function automatic logic [4:0] strobeLen(input logic stretch);
        strobeLen = stretch ? 5'(`STROBE_LONG_PERIODS) : 5'(`STROBE_SHORT_PERIODS); // RL11 RL12
    endfunction : strobeLen

    logic coreX2;
    logic [4:0] periodCount;
    logic cycleEnd;
    logic halfPoint;
    logic wbReq;
    logic eaEffective;

    assign coreX2 = st_r.clk0[`CK0_CORE_X2_BIT];
    // machine cycle length from double speed bit
    assign periodCount = coreX2 ? 5'(`FAST_PERIODS) : 5'(`SLOW_PERIODS); // RL8
    assign wbReq = wb_cyc_i && wb_stb_i && !st_r.ack;
    // latched access select under protection, else live pin
    assign eaEffective = protectLevel1 ? st_r.eaLatched : externalAccessSelect_n; // RL7

    cycle_divider #(
        .MAX_PERIODS(`SLOW_PERIODS)
    ) u_div (
        .core_clk(core_clk),
        .rst(rst),
        .periodCount(periodCount),
        .cycleEnd(cycleEnd),
        .halfPoint(halfPoint)
    );

    // next state: registers, bus sequencing
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.done = 1'b0;
        // register writes; reserved bits are kept zero
        if (wbReq && wb_we_i) begin
            unique case (wb_adr_i)
                `AUX_CTRL_ADDR: st_nxt.aux = wb_dat_i & `AUX_WRITE_MASK; // RL14
                `CLK_CTRL0_ADDR: st_nxt.clk0 = wb_dat_i; // RL8
                `CLK_CTRL1_ADDR: st_nxt.clk1 = {7'h00, wb_dat_i[0]};
                default: ;
            endcase
        end
        if (wbReq) begin
            st_nxt.ack = 1'b1;
        end
        unique case (st_r.phase)
            PH_IDLE: begin
                // wait for a request at cycle end
                st_nxt.busDrive = 1'b0;
                st_nxt.fetchN = 1'b1;
                if (cycleEnd && coreReq != REQ_NONE) begin
                    if (coreReq == REQ_CODE && internalCodeHit && eaEffective) begin
                        st_nxt.done = 1'b1; // RL5
                    end else if (coreReq != REQ_CODE && !st_r.aux[`AUX_EXTDATA_BIT]) begin
                        st_nxt.done = 1'b1; // RL15
                    end else begin
                        st_nxt.req = coreReq;
                        st_nxt.phase = PH_ADDR;
                        st_nxt.busOut = coreAddr[7:0]; // RL1
                        st_nxt.busDrive = 1'b1; // RL2
                        st_nxt.addrHi = coreAddr[15:8];
                        st_nxt.ale = 1'b1;
                        st_nxt.secondHalf = 1'b0;
                    end
                end
            end
            PH_ADDR: begin
                // address phase ends, then fetch or data strobe
                st_nxt.ale = 1'b0;
                if (st_r.req == REQ_CODE) begin
                    st_nxt.phase = PH_FETCH;
                    st_nxt.busDrive = 1'b0;
                    st_nxt.fetchN = 1'b0; // RL3
                end else begin
                    st_nxt.phase = PH_DATA;
                    st_nxt.strobeCnt = strobeLen(st_r.aux[`AUX_STRETCH_BIT]);
                    st_nxt.busOut = coreWrData; // RL1
                    st_nxt.busDrive = (st_r.req == REQ_DWRITE);
                    st_nxt.rdN = (st_r.req != REQ_DREAD);
                    st_nxt.wrN = (st_r.req != REQ_DWRITE);
                end
            end
            PH_FETCH: begin
                // two strobes per machine cycle, one each half
                if (halfPoint || cycleEnd) begin
                    st_nxt.fetchN = 1'b1;
                    st_nxt.rdData = addrData_i;
                    if (!st_r.secondHalf) begin
                        st_nxt.secondHalf = 1'b1;
                        st_nxt.phase = PH_HOLD;
                    end else begin
                        st_nxt.done = 1'b1;
                        st_nxt.phase = PH_IDLE;
                    end
                end
            end
            PH_HOLD: begin
                // second fetch strobe of the same machine cycle
                st_nxt.fetchN = 1'b0; // RL3
                st_nxt.phase = PH_FETCH;
            end
            PH_DATA: begin
                // data strobe, fetch strobe held off throughout
                st_nxt.fetchN = 1'b1; // RL4
                st_nxt.strobeCnt = st_r.strobeCnt - 5'h01;
                if (st_r.strobeCnt == 5'h01) begin
                    st_nxt.rdN = 1'b1;
                    st_nxt.wrN = 1'b1;
                    st_nxt.rdData = addrData_i;
                    st_nxt.busDrive = 1'b0;
                    st_nxt.done = 1'b1;
                    st_nxt.phase = PH_IDLE;
                end
            end
            default: st_nxt.phase = PH_IDLE;
        endcase
    end

    // state register, reset loads settings from security byte
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= '0;
            st_r.aux[`AUX_XRS_HI_BIT] <= 1'b1; // RL16
            st_r.aux[`AUX_XRS_LO_BIT] <= 1'b1; // RL16
            st_r.aux[`AUX_EXTDATA_BIT] <= securityExtData; // RL15
            st_r.clk0[`CK0_CORE_X2_BIT] <= securityDoubleSpeed; // RL9
            st_r.eaLatched <= externalAccessSelect_n; // RL7
            st_r.fetchN <= 1'b1;
            st_r.rdN <= 1'b1;
            st_r.wrN <= 1'b1;
            st_r.phase <= PH_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // register read mux, status shows block state
    always_comb begin
        unique case (wb_adr_i)
            `AUX_CTRL_ADDR: wb_dat_o = st_r.aux;
            `CLK_CTRL0_ADDR: wb_dat_o = st_r.clk0;
            `CLK_CTRL1_ADDR: wb_dat_o = st_r.clk1;
            `MEM_STATUS_ADDR: wb_dat_o = {4'h0, eaEffective, st_r.phase};
            default: wb_dat_o = 8'h00;
        endcase
    end
    assign wb_ack_o = st_r.ack;

    // peripheral fast bits gated by core double speed
    assign periphFast = coreX2 ? {st_r.clk1[`CK1_SPI_X2_BIT], st_r.clk0[6:1]} : 7'h00; // RL10
    assign weakPullupOn = !st_r.aux[`AUX_PULLUP_DIS_BIT]; // RL13
    assign useExternalCode = !eaEffective; // RL6
    assign useExpansionRam = !st_r.aux[`AUX_EXTDATA_BIT];
    assign expansionRamBytes = {1'b0, st_r.aux[`AUX_XRS_HI_BIT:`AUX_XRS_LO_BIT], 8'h00} + 11'h100; // RL16
    assign cycleTick = cycleEnd;
    assign coreDone = st_r.done;
    assign coreRdData = st_r.rdData;
    assign addrData_o = st_r.busOut;
    // driven bits are strong in both levels
    assign addrData_oe_n = {8{!st_r.busDrive}}; // RL2
    assign addrHigh = st_r.addrHi;
    assign addrLatch = st_r.ale;
    assign programFetchStrobe_n = st_r.fetchN;
    assign readStrobe_n = st_r.rdN;
    assign writeStrobe_n = st_r.wrN;

    // a data cycle never shows a fetch strobe
    chk_data_no_fetch: assert property (@(posedge core_clk) disable iff (rst) // RL4
        st_r.phase == PH_DATA |-> programFetchStrobe_n) else $error("fetch strobe in data cycle");
    // short strobe lasts six periods
    sequence shortStrobe;
        !readStrobe_n [*6] ##1 readStrobe_n;
    endsequence
    chk_short_strobe: assert property (@(posedge core_clk) disable iff (rst) // RL11
        $fell(readStrobe_n) && !st_r.aux[`AUX_STRETCH_BIT] |-> shortStrobe) else $error("read strobe not 6");
    // short write strobe lasts six periods as well
    sequence shortWrite;
        !writeStrobe_n [*6] ##1 writeStrobe_n;
    endsequence
    chk_short_write: assert property (@(posedge core_clk) disable iff (rst) // RL11
        $fell(writeStrobe_n) && !st_r.aux[`AUX_STRETCH_BIT] |-> shortWrite) else $error("write strobe not 6");
    // low-time counter of the data strobes, too long to unroll as a repetition
    logic [5:0] lowCnt;
    always_ff @(posedge core_clk) begin
        lowCnt <= (rst || readStrobe_n && writeStrobe_n) ? 6'h00 : lowCnt + 6'h01;
    end
    // the counter holds the full low time when the strobe rises
    chk_long_strobe: assert property (@(posedge core_clk) disable iff (rst) // RL12
        $rose(readStrobe_n && writeStrobe_n) && st_r.aux[`AUX_STRETCH_BIT] |-> lowCnt == 6'd30)
        else $error("stretched strobe not 30");
    // the hold slot is followed by the second fetch strobe
    chk_two_fetches: assert property (@(posedge core_clk) disable iff (rst) // RL3
        st_r.phase == PH_HOLD |-> ##1 !programFetchStrobe_n) else $error("second fetch missing");
    // an internal code fetch leaves the bus asleep
    chk_internal_quiet: assert property (@(posedge core_clk) disable iff (rst) // RL5
        st_r.phase == PH_IDLE && cycleEnd && coreReq == REQ_CODE && internalCodeHit && eaEffective
        |-> ##1 programFetchStrobe_n && st_r.phase == PH_IDLE) else $error("fetch on internal code");
    // no strobe at all while the sequencer rests
    chk_idle_quiet: assert property (@(posedge core_clk) disable iff (rst) // RL5
        st_r.phase == PH_IDLE |-> programFetchStrobe_n && readStrobe_n && writeStrobe_n)
        else $error("strobe while idle");
    // the low address is driven while the latch pulse stands
    chk_bus_drive: assert property (@(posedge core_clk) disable iff (rst) // RL1 RL2
        addrLatch |-> addrData_oe_n == 8'h00) else $error("address not driven");
    // address phase, then a strobe in the very next cycle
    sequence addrPhase;
        addrLatch && addrData_oe_n == 8'h00;
    endsequence
    sequence strobeFollows;
        ##1 (!programFetchStrobe_n || !readStrobe_n || !writeStrobe_n);
    endsequence
    chk_addr_then_data: assert property (@(posedge core_clk) disable iff (rst) // RL1
        addrPhase |-> strobeFollows) else $error("no strobe after address");
    // latch pulse lasts a single cycle
    chk_latch_pulse: assert property (@(posedge core_clk) disable iff (rst) // RL1
        addrLatch |=> !addrLatch) else $error("latch pulse too long");
    // bus released while memory answers a read or a fetch
    chk_read_released: assert property (@(posedge core_clk) disable iff (rst) // RL1
        !readStrobe_n || st_r.phase == PH_FETCH |-> addrData_oe_n == 8'hFF) else $error("bus driven on read");
    // write data driven strongly for the whole strobe
    chk_write_drive: assert property (@(posedge core_clk) disable iff (rst) // RL2
        !writeStrobe_n |-> addrData_oe_n == 8'h00) else $error("write data not driven");
    // peripheral fast bits are masked at standard speed
    chk_periph_gate: assert property (@(posedge core_clk) disable iff (rst) // RL10
        !coreX2 |-> periphFast == 7'h00) else $error("fast peripheral without x2");
    // a write of the pull-up bit acts in the next cycle
    chk_pullup_bit: assert property (@(posedge core_clk) disable iff (rst) // RL13
        wbReq && wb_we_i && wb_adr_i == `AUX_CTRL_ADDR |=> weakPullupOn == !$past(wb_dat_i[7]))
        else $error("pull-up disable ignored");
    // reserved auxiliary bits never hold a one
    chk_reserved_zero: assert property (@(posedge core_clk) disable iff (rst) // RL14
        st_r.aux[6] == 1'b0 && st_r.aux[4] == 1'b0) else $error("reserved bit set");
    // speed after reset follows the security byte
    chk_speed_reset: assert property (@(posedge core_clk) disable iff (rst) // RL9
        $fell(rst) |-> coreX2 == $past(securityDoubleSpeed)) else $error("speed not from security byte");
    // data select and size code after reset
    chk_aux_reset: assert property (@(posedge core_clk) disable iff (rst) // RL15 RL16
        $fell(rst) |-> st_r.aux[`AUX_EXTDATA_BIT] == $past(securityExtData) && st_r.aux[3:2] == 2'b11)
        else $error("aux reset value wrong");
    // access select latched during reset under protection
    chk_access_latch: assert property (@(posedge core_clk) disable iff (rst) // RL7
        $fell(rst) && protectLevel1 |-> eaEffective == $past(externalAccessSelect_n))
        else $error("access select not latched");
endmodule : ext_bus_ctrl

// ---- hw/ext_bus_pkg.sv ----
// types shared by the external bus control
package ext_bus_pkg;
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_ADDR = 3'b001,
        PH_FETCH = 3'b010,
        PH_DATA = 3'b011,
        PH_HOLD = 3'b100
    } bus_phase_t;
    typedef enum logic [1:0] {
        REQ_NONE = 2'b00,
        REQ_CODE = 2'b01,
        REQ_DREAD = 2'b10,
        REQ_DWRITE = 2'b11
    } bus_req_t;
endpackage : ext_bus_pkg

// ---- tb/ext_bus_ctrl_tb_top.sv ----
`timescale 1ns/100ps
// self-checking bench of the external bus control
`include "ext_bus_consts.svh"
module ext_bus_ctrl_tb_top;
    import ext_bus_pkg::*;
    logic core_clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 8'h00, wb_dat_i = 8'h00, wb_dat_o, coreRdData, addrData_o, addrData_oe_n, addrHigh;
    logic securityDoubleSpeed = 0, securityExtData = 1, protectLevel1 = 0, extSel_n = 0, internalCodeHit = 0;
    bus_req_t coreReq = REQ_NONE;
    logic [15:0] coreAddr = 16'h0000, curAddr = 16'h0000;
    logic [7:0] coreWrData = 8'h00, memData, lastWrite, padLevel, rnd;
    logic wb_ack_o, coreDone, useExternalCode, useExpansionRam, weakPullupOn, cycleTick, addrLatch;
    logic programFetchStrobe_n, readStrobe_n, writeStrobe_n, prevF = 1;
    logic [10:0] expansionRamBytes;
    logic [6:0] periphFast;
    int nErrors = 0, totalChecks = 0, falls = 0, rdLow = 0, wrLow = 0;
    logic [15:0] rdQ[$], coreQ[$];
    // wire level: design drives where its enable is low, memory elsewhere
    assign padLevel = (addrData_o & ~addrData_oe_n) | (memData & addrData_oe_n);
    ext_bus_ctrl u_ext_bus_ctrl (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .securityDoubleSpeed(securityDoubleSpeed), .securityExtData(securityExtData),
        .protectLevel1(protectLevel1), .externalAccessSelect_n(extSel_n), .coreReq(coreReq),
        .coreAddr(coreAddr), .coreWrData(coreWrData), .internalCodeHit(internalCodeHit), .coreDone(coreDone),
        .coreRdData(coreRdData), .useExternalCode(useExternalCode), .useExpansionRam(useExpansionRam),
        .expansionRamBytes(expansionRamBytes), .periphFast(periphFast), .weakPullupOn(weakPullupOn),
        .cycleTick(cycleTick), .addrData_i(padLevel), .addrData_o(addrData_o), .addrData_oe_n(addrData_oe_n),
        .addrHigh(addrHigh), .addrLatch(addrLatch), .programFetchStrobe_n(programFetchStrobe_n),
        .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n));
    ext_mem_model u_ext_mem_model (.core_clk(core_clk), .addrLatch(addrLatch), .busLevel(padLevel),
        .addrHigh(addrHigh), .fetchStrobe_n(programFetchStrobe_n), .readStrobe_n(readStrobe_n),
        .writeStrobe_n(writeStrobe_n), .memData(memData), .lastWrite(lastWrite));
    // 250 MHz clock
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    // verdict and end of run
    task automatic stopTest;
        $display("checks %0d mismatches %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stopTest
    // compare one value
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        totalChecks++;
        if (g !== e) begin
            nErrors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // classic wishbone single cycle, waits for ack
    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (n >= 100) begin
            nErrors++;
            stopTest();
        end
    endtask : wb
    // register read whose expected value is noted for the watcher
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rdQ.push_back({8'h00, e});
        wb(1'b0, a, 8'h00);
    endtask : rd
    // one core request; strobe counts compared after completion
    task automatic core(input bus_req_t r, input logic [15:0] a, input int eF, input int eR, input int eW);
        int n, f0, r0, w0;
        n = 0;
        @(posedge core_clk);
        f0 = falls;
        r0 = rdLow;
        w0 = wrLow;
        curAddr = a;
        rnd = 8'($urandom);
        coreReq <= r;
        coreAddr <= a;
        coreWrData <= rnd;
        if (r == REQ_DREAD && eR > 0) coreQ.push_back({8'h00, a[7:0] ^ a[15:8] ^ 8'h5A});
        do begin
            @(posedge core_clk);
            n++;
        end while (coreDone !== 1'b1 && n < 300);
        coreReq <= REQ_NONE;
        if (n >= 300) begin
            nErrors++;
            stopTest();
        end
        chk(16'(falls - f0), 16'(eF));
        chk(16'(rdLow - r0), 16'(eR));
        chk(16'(wrLow - w0), 16'(eW));
        if (r == REQ_DWRITE && eW > 0) chk({8'h00, lastWrite}, {8'h00, rnd});
    endtask : core
    // machine cycle length between two ticks
    task automatic tickp(input int e);
        int n;
        repeat (2) begin
            n = 0;
            do begin
                @(posedge core_clk);
                n++;
            end while (cycleTick !== 1'b1 && n < 50);
        end
        if (n >= 50) begin
            nErrors++;
            stopTest();
        end
        chk(16'(n), 16'(e));
    endtask : tickp
    // synchronous reset with given security settings, access strap held low
    task automatic doReset(input logic dbl, input logic pl1);
        @(posedge core_clk);
        {rst, securityDoubleSpeed, protectLevel1, extSel_n} <= {1'b1, dbl, pl1, 1'b0};
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
    endtask : doReset
    // strobe counters and bus checks at the latch pulse
    always @(posedge core_clk) begin
        falls <= falls + int'(prevF && !programFetchStrobe_n);
        prevF <= programFetchStrobe_n;
        rdLow <= rdLow + int'(!readStrobe_n);
        wrLow <= wrLow + int'(!writeStrobe_n);
        if (addrLatch === 1'b1) chk({addrHigh, addrData_o}, curAddr);
        if (addrLatch === 1'b1) chk({8'h00, addrData_oe_n}, 16'h0000);
        if (wb_ack_o === 1'b1 && !wb_we_i && rdQ.size() > 0) chk({8'h00, wb_dat_o}, rdQ.pop_front());
        if (coreDone === 1'b1 && coreQ.size() > 0) chk({8'h00, coreRdData}, coreQ.pop_front());
    end
    // main sequence
    initial begin
        void'($urandom(32'hD55622E5));
        doReset(1'b0, 1'b0);
        rd(`AUX_CTRL_ADDR, 8'h0E);
        rd(`CLK_CTRL0_ADDR, 8'h00);
        rd(8'hA0, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, `AUX_CTRL_ADDR, 8'(c << 2) | 8'h02);
            chk({5'h00, expansionRamBytes}, 16'(256 * (c + 1)));
            chk({15'h0, weakPullupOn}, 16'h0001);
        end
        wb(1'b1, `AUX_CTRL_ADDR, 8'h8E);
        rd(`AUX_CTRL_ADDR, 8'h8E);
        chk({15'h0, weakPullupOn}, 16'h0000);
        $display("test registers done");
        core(REQ_DREAD, 16'($urandom), 0, 6, 0);
        core(REQ_DWRITE, 16'($urandom), 0, 0, 6);
        wb(1'b1, `AUX_CTRL_ADDR, 8'h2E);
        core(REQ_DREAD, 16'($urandom), 0, 30, 0);
        core(REQ_DWRITE, 16'($urandom), 0, 0, 30);
        core(REQ_CODE, 16'($urandom), 2, 0, 0);
        wb(1'b1, `AUX_CTRL_ADDR, 8'h0C);
        chk({15'h0, useExpansionRam}, 16'h0001);
        core(REQ_DREAD, 16'($urandom), 0, 0, 0);
        tickp(12);
        $display("test bus cycles done");
        doReset(1'b1, 1'b1);
        extSel_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk({15'h0, useExternalCode}, 16'h0001);
        rd(`CLK_CTRL0_ADDR, 8'h01);
        tickp(6);
        rnd = 8'($urandom);
        wb(1'b1, `CLK_CTRL0_ADDR, {1'b0, rnd[5:0], 1'b1});
        wb(1'b1, `CLK_CTRL1_ADDR, 8'h01);
        chk({9'h0, periphFast}, {9'h0, 1'b1, rnd[5:0]});
        wb(1'b1, `CLK_CTRL0_ADDR, {1'b0, rnd[5:0], 1'b0});
        chk({9'h0, periphFast}, 16'h0000);
        tickp(12);
        protectLevel1 <= 1'b0;
        internalCodeHit <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk({15'h0, useExternalCode}, 16'h0000);
        core(REQ_CODE, 16'h0010, 0, 0, 0);
        chk(16'(coreQ.size() + rdQ.size()), 16'h0000);
        $display("test speed and access done");
        stopTest();
    end
endmodule : ext_bus_ctrl_tb_top

// ---- tb/ext_mem_model.sv ----
`timescale 1ns/100ps
// behavioural external program and data memory on the multiplexed bus
module ext_mem_model (
    input wire logic core_clk,
    input wire logic addrLatch,
    input wire logic [7:0] busLevel,
    input wire logic [7:0] addrHigh,
    input wire logic fetchStrobe_n,
    input wire logic readStrobe_n,
    input wire logic writeStrobe_n,
    output logic [7:0] memData,
    output logic [7:0] lastWrite
);
    logic [7:0] lowAddr_r = 8'h00; // low address caught from the bus
    logic [7:0] idle_r = 8'h00; // pattern shown while released
    // catch the address at the latch pulse and the data while the write strobe is low
    always_ff @(posedge core_clk) begin
        if (addrLatch) lowAddr_r <= busLevel;
        if (!writeStrobe_n) lastWrite <= busLevel;
        idle_r <= ~memData;
    end
    // content answers at once; released bus shows the inverse of the last value
    assign memData = (!readStrobe_n || !fetchStrobe_n) ? (lowAddr_r ^ addrHigh ^ 8'h5A) : idle_r;
endmodule : ext_mem_model
